/* lhp_defs.svh */
`ifndef LHP_DEFS_SVH
`define LHP_DEFS_SVH
`define LHP_CMD_DISP_OFF 8'hae
`define LHP_CMD_DISP_ON 8'haf
`define LHP_CMD_SEG_NORM 8'ha0
`define LHP_CMD_SEG_REV 8'ha1
`define LHP_CMD_BIAS_9 8'ha2
`define LHP_CMD_BIAS_7 8'ha3
`define LHP_CMD_ALL_OFF 8'ha4
`define LHP_CMD_ALL_ON 8'ha5
`define LHP_CMD_INV_OFF 8'ha6
`define LHP_CMD_INV_ON 8'ha7
`define LHP_CMD_RMW 8'he0
`define LHP_CMD_RMW_END 8'hee
`define LHP_CMD_RESET 8'he2
`define LHP_CMD_VOL_MODE 8'h81
`define LHP_PFX_START 2'h1
`define LHP_PFX_PAGE 4'hb
`define LHP_PFX_COL_HI 4'h1
`define LHP_PFX_COL_LO 4'h0
`define LHP_PFX_COM_DIR 4'hc
`define LHP_PFX_POWER 5'h05
`define LHP_STATUS_LO 4'h0
`define LHP_SER_MSB 3'h7
`define LHP_PAGES 16
`define LHP_COLS 256
`endif

/* lhp_pkg.sv */
package lhp_pkg;
  typedef struct packed {
    logic display_on;
    logic [5:0] start_line;
    logic seg_reverse;
    logic invert;
    logic all_on;
    logic bias_seventh;
    logic com_reverse;
    logic [2:0] power_mode;
    logic [5:0] volume;
  } lhp_mode_t;
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] column;
    logic rmw;
  } lhp_addr_t;
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } lhp_byte_t;
endpackage

/* lhp_sync.sv */
`timescale 1ns/1ps
module lhp_sync import lhp_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // lhp_sync

/* lhp_serial_rx.sv */
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_serial_rx import lhp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic clk_rise,
  input wire logic serial_in,
  input wire logic dc_sel,
  output lhp_byte_t rx_byte,
  output logic rx_valid
);
  logic [2:0] count;
  logic [6:0] shift;
  wire last_bit = (count == `LHP_SER_MSB);
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      count <= '0;
      shift <= '0;
      rx_valid <= 1'b0;
      rx_byte <= '0;
    end else begin
      rx_valid <= clk_rise && last_bit;
      if (clk_rise) begin
        count <= count + 3'h1;
        shift <= {shift[5:0], serial_in};
        if (last_bit) begin
          // Select line is sampled together with the eighth bit.
          rx_byte <= '{is_data: dc_sel, value: {shift, serial_in}};
        end
      end
    end
  end
endmodule // lhp_serial_rx

/* lhp_host_port.sv */
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_host_port import lhp_pkg::*; #(
  parameter int PAGES = `LHP_PAGES,
  parameter int COLS = `LHP_COLS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic parallel_serial_pin,
  input wire logic bus_style_select,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic read_strobe_pin,
  input wire logic write_strobe_pin,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  output lhp_mode_t mode,
  output lhp_addr_t addr,
  output logic [3:0] status_flags
);
  localparam int IN_W = 15;
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] syn_in;
  logic par_sel, style_6800, cs_n, dc, rd_pin, wr_pin, res_n;
  logic [7:0] bus;
  logic wr_prev, rd_prev, sclk_prev;
  logic [7:0] ram [PAGES*COLS];
  lhp_mode_t next_mode;
  lhp_addr_t next_addr;
  logic vol_pending, next_vol_pending;
  logic [7:0] rd_byte;
  logic active_reset;
  assign raw_in = {reset_n, parallel_serial_pin, bus_style_select, chip_select_n,
                   data_command_select, read_strobe_pin, write_strobe_pin, data_in};
  lhp_sync #(.WIDTH(IN_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn_in)
  );
  assign {res_n, par_sel, style_6800, cs_n, dc, rd_pin, wr_pin, bus} = syn_in;
  wire selected = !cs_n;
  // Parallel strobes.
  wire is_par = par_sel && selected;
  wire wr_8080 = is_par && !style_6800 && wr_pin && !wr_prev;
  wire e_fall = rd_prev && !rd_pin;
  wire wr_6800 = is_par && style_6800 && e_fall && !wr_pin;
  wire rd_8080_on = is_par && !style_6800 && !rd_pin;
  wire rd_6800_on = is_par && style_6800 && rd_pin && wr_pin;
  wire drive_bus = rd_8080_on || rd_6800_on;
  wire rd_end_8080 = is_par && !style_6800 && rd_pin && !rd_prev;
  wire rd_end_6800 = is_par && style_6800 && e_fall && wr_pin;
  wire rd_done = rd_end_8080 || rd_end_6800;
  // Serial link on bit 7 data and bit 6 clock.
  wire ser_en = !par_sel && selected;
  wire sclk = bus[6];
  wire sclk_rise = sclk && !sclk_prev;
  lhp_byte_t ser_byte;
  logic ser_valid;
  lhp_serial_rx u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n && res_n),
    .enable(ser_en),
    .clk_rise(sclk_rise),
    .serial_in(bus[7]),
    .dc_sel(dc),
    .rx_byte(ser_byte),
    .rx_valid(ser_valid)
  );
  wire par_wr = wr_8080 || wr_6800;
  wire wr_valid = par_wr || ser_valid;
  wire [7:0] wr_val = par_wr ? bus : ser_byte.value;
  wire wr_is_data = par_wr ? dc : ser_byte.is_data;
  wire cmd_valid = wr_valid && !wr_is_data;
  wire ram_wr = wr_valid && wr_is_data;
  wire [11:0] ram_idx = {addr.page, addr.column};
  assign rd_byte = dc ? ram[ram_idx] : {status_flags, `LHP_STATUS_LO};
  assign active_reset = cmd_valid && !vol_pending && wr_val == `LHP_CMD_RESET;
  // Status shows rmw, display off and reset-in-progress in the upper nibble.
  // The flags are registered beside mode and addr so they always match them.
  always_comb begin
    next_mode = mode;
    next_addr = addr;
    next_vol_pending = vol_pending;
    if (cmd_valid) begin
      if (vol_pending) begin
        next_mode.volume = wr_val[5:0];
        next_vol_pending = 1'b0;
      end else if (wr_val == `LHP_CMD_RESET) begin
        next_mode = '0;
        next_addr = '0;
      end else if (wr_val == `LHP_CMD_VOL_MODE) begin
        next_vol_pending = 1'b1;
      end else if (wr_val[7:1] == 7'(`LHP_CMD_DISP_OFF >> 1)) begin
        next_mode.display_on = wr_val[0];
      end else if (wr_val[7:1] == 7'(`LHP_CMD_SEG_NORM >> 1)) begin
        next_mode.seg_reverse = wr_val[0];
      end else if (wr_val[7:1] == 7'(`LHP_CMD_INV_OFF >> 1)) begin
        next_mode.invert = wr_val[0];
      end else if (wr_val[7:1] == 7'(`LHP_CMD_ALL_OFF >> 1)) begin
        next_mode.all_on = wr_val[0];
      end else if (wr_val[7:1] == 7'(`LHP_CMD_BIAS_9 >> 1)) begin
        next_mode.bias_seventh = wr_val[0];
      end else if (wr_val == `LHP_CMD_RMW) begin
        next_addr.rmw = 1'b1;
      end else if (wr_val == `LHP_CMD_RMW_END) begin
        next_addr.rmw = 1'b0;
      end else if (wr_val[7:6] == `LHP_PFX_START) begin
        next_mode.start_line = wr_val[5:0];
      end else if (wr_val[7:4] == `LHP_PFX_PAGE) begin
        next_addr.page = wr_val[3:0];
      end else if (wr_val[7:4] == `LHP_PFX_COL_HI) begin
        next_addr.column[7:4] = wr_val[3:0];
      end else if (wr_val[7:4] == `LHP_PFX_COL_LO) begin
        next_addr.column[3:0] = wr_val[3:0];
      end else if (wr_val[7:4] == `LHP_PFX_COM_DIR) begin
        next_mode.com_reverse = wr_val[3];
      end else if (wr_val[7:3] == `LHP_PFX_POWER) begin
        next_mode.power_mode = wr_val[2:0];
      end
    end else if (ram_wr && addr.rmw) begin
      next_addr.column = addr.column + 8'h01;
    end
  end
  // RAM is left untouched by either reset so stored pixels survive.
  always_ff @(posedge core_clk) begin
    if (ram_wr) begin
      ram[ram_idx] <= wr_val;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n || !res_n) begin
      mode <= '0;
      addr <= '0;
      vol_pending <= 1'b0;
      status_flags <= {1'b0, 1'b0, 1'b1, !res_n};
    end else begin
      mode <= next_mode;
      addr <= next_addr;
      vol_pending <= next_vol_pending;
      status_flags <= {1'b0, next_addr.rmw, !next_mode.display_on, 1'b0};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b0;
      sclk_prev <= 1'b0;
      data_out <= '0;
      data_oe_n <= 8'hff;
    end else begin
      wr_prev <= wr_pin;
      rd_prev <= rd_pin;
      sclk_prev <= sclk;
      data_out <= rd_byte;
      data_oe_n <= (drive_bus && selected) ? 8'h00 : 8'hff;
    end
  end
endmodule // lhp_host_port

/* lhp_checker.sv */
`timescale 1ns/1ps
module lhp_checker import lhp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic parallel_serial_pin,
  input wire logic bus_style_select,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic read_strobe_pin,
  input wire logic write_strobe_pin,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  input wire lhp_mode_t mode,
  input wire lhp_addr_t addr,
  input wire logic [3:0] status_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire par_sel = parallel_serial_pin && !chip_select_n;
  property p_cs_idle; chip_select_n[*6] |-> data_oe_n == 8'hff; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("bus driven unselected");
  property p_rd80; (par_sel && !bus_style_select && !read_strobe_pin)[*6] |-> data_oe_n == 8'h00; endproperty
  a_rd80: assert property (p_rd80) else $error("8080 read not driven");
  property p_rd80_off; (!bus_style_select && read_strobe_pin)[*6] |-> data_oe_n == 8'hff; endproperty
  a_rd80_off: assert property (p_rd80_off) else $error("8080 bus driven idle");
  property p_rd68; (par_sel && bus_style_select && read_strobe_pin && write_strobe_pin)[*6] |-> data_oe_n == 8'h00; endproperty
  a_rd68: assert property (p_rd68) else $error("6800 read not driven");
  property p_ser; (!parallel_serial_pin)[*6] |-> data_oe_n == 8'hff; endproperty
  a_ser: assert property (p_ser) else $error("serial mode drives bus");
  property p_stat_lo; (!data_oe_n[0] && !data_command_select)[*6] |-> data_out[3:0] == 4'h0; endproperty
  a_stat_lo: assert property (p_stat_lo) else $error("status low nibble");
  property p_stat_map; status_flags[3:1] == {1'b0, addr.rmw, !mode.display_on}; endproperty
  a_stat_map: assert property (p_stat_map) else $error("status flags");
  property p_hold; (chip_select_n && reset_n)[*6] |=> $stable(mode) && $stable(addr); endproperty
  a_hold: assert property (p_hold) else $error("state moved unselected");
  property p_pin_rst; (!reset_n)[*5] |-> mode == '0 && addr == '0; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset");
endmodule // lhp_checker

/* lhp_host_model.sv */
`timescale 1ns/1ps
module lhp_host_model import lhp_pkg::*; (
  input wire logic core_clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  output logic parallel_serial_pin,
  output logic bus_style_select,
  output logic chip_select_n,
  output logic data_command_select,
  output logic read_strobe_pin,
  output logic write_strobe_pin,
  output logic [7:0] data_in
);
  logic drive;
  logic [7:0] hd;
  logic [7:0] last = 8'h00;
  // A released line shows the inverse of its last level, so stale data cannot pass.
  always @(posedge core_clk) last <= data_in;
  assign data_in = (~data_oe_n & data_out) | (data_oe_n & (drive ? hd : ~last));
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic setup(input logic par, input logic m68);
    parallel_serial_pin = par;
    bus_style_select = m68;
    chip_select_n = 1'b1;
    data_command_select = 1'b0;
    read_strobe_pin = !m68;
    write_strobe_pin = 1'b1;
    drive = !par;
    hd = 8'h3f;
    cycles(8);
  endtask
  task automatic xfer(input logic cs_n, input logic rd, input logic dc, input logic [7:0] v,
                      output logic [7:0] got);
    cycles(1);
    chip_select_n = cs_n;
    data_command_select = dc;
    drive = !rd;
    hd = v;
    if (bus_style_select) begin
      write_strobe_pin = rd;
      read_strobe_pin = 1'b1;
    end else if (rd) begin
      read_strobe_pin = 1'b0;
    end else begin
      write_strobe_pin = 1'b0;
    end
    cycles(8);
    got = data_in;
    read_strobe_pin = !bus_style_select;
    write_strobe_pin = bus_style_select ? write_strobe_pin : 1'b1;
    cycles(8);
    write_strobe_pin = 1'b1;
    drive = 1'b0;
    chip_select_n = 1'b1;
  endtask
  task automatic ser(input logic dc, input logic [7:0] v);
    chip_select_n = 1'b0;
    data_command_select = dc;
    for (int i = 7; i >= 0; i--) begin
      hd = {v[i], 1'b0, 6'h3f};
      cycles(13);
      hd[6] = 1'b1;
      cycles(12);
    end
    hd = 8'h3f;
    cycles(8);
    chip_select_n = 1'b1;
  endtask
endmodule // lhp_host_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import lhp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_n = 1'b1;
  logic parallel_serial_pin, bus_style_select, chip_select_n, data_command_select;
  logic read_strobe_pin, write_strobe_pin;
  logic [7:0] data_in, data_out, data_oe_n, got;
  logic [3:0] status_flags;
  lhp_mode_t mode;
  lhp_addr_t addr;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] on_seq [12] = '{8'haf, 8'h6a, 8'ha1, 8'ha7, 8'ha5, 8'ha3, 8'hcf, 8'h2d, 8'h81,
                              8'h65, 8'hb7, 8'h1a};
  logic [7:0] off_seq [7] = '{8'h0c, 8'hae, 8'ha0, 8'ha6, 8'ha4, 8'ha2, 8'hc7};
  lhp_host_port dut(.core_clk, .rst_n, .reset_n, .parallel_serial_pin, .bus_style_select,
    .chip_select_n, .data_command_select, .read_strobe_pin, .write_strobe_pin, .data_in,
    .data_out, .data_oe_n, .mode, .addr, .status_flags);
  lhp_host_model host(.core_clk, .data_out, .data_oe_n, .parallel_serial_pin,
    .bus_style_select, .chip_select_n, .data_command_select, .read_strobe_pin,
    .write_strobe_pin, .data_in);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    host.xfer(1'b0, 1'b0, 1'b0, c, got);
  endtask
  task automatic t_modes;
    foreach (on_seq[i]) cmd(on_seq[i]);
    cmd(off_seq[0]);
    chk(32'(mode), 32'({1'b1, 6'h2a, 5'h1f, 3'h5, 6'h25}));
    chk(32'(addr), 32'({4'h7, 8'hac, 1'b0}));
    foreach (off_seq[i]) cmd(off_seq[i]);
    chk(32'(mode), 32'({1'b0, 6'h2a, 5'h00, 3'h5, 6'h25}));
    host.xfer(1'b1, 1'b0, 1'b0, 8'haf, got);
    chk(32'(mode.display_on), 32'h0);
  endtask
  task automatic t_rmw;
    host.setup(1'b1, 1'b1);
    cmd(8'he0);
    host.xfer(1'b0, 1'b0, 1'b1, 8'h5a, got);
    chk(32'(addr.column), 32'h0ad);
    host.xfer(1'b0, 1'b1, 1'b0, 8'h00, got);
    chk(32'(got), 32'h60);
    cmd(8'h0c);
    host.xfer(1'b0, 1'b1, 1'b1, 8'h00, got);
    chk(32'(got), 32'h5a);
    chk(32'(addr.column), 32'h0ac);
    cmd(8'hee);
    chk(32'(addr.rmw), 32'h0);
  endtask
  task automatic t_serial;
    host.setup(1'b0, 1'b0);
    host.ser(1'b0, 8'haf);
    host.ser(1'b1, 8'h33);
    chk(32'(mode.display_on), 32'h1);
    chk(32'(addr.column), 32'h0ac);
    host.setup(1'b1, 1'b0);
    host.xfer(1'b0, 1'b1, 1'b1, 8'h00, got);
    chk(32'(got), 32'h33);
  endtask
  task automatic t_reset;
    cmd(8'he2);
    chk(32'(mode), 32'h0);
    chk(32'(addr), 32'h0);
    cmd(8'hb7);
    cmd(8'h1a);
    cmd(8'h0c);
    host.xfer(1'b0, 1'b1, 1'b1, 8'h00, got);
    chk(32'(got), 32'h33);
    cmd(8'haf);
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(32'(mode), 32'h0);
    chk(32'(addr), 32'h0);
    reset_n = 1'b1;
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    host.setup(1'b1, 1'b0);
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_modes();
    t_rmw();
    t_serial();
    t_reset();
    complete_run();
  end
endmodule // tb
bind lhp_host_port lhp_checker chk_i(.core_clk, .rst_n, .reset_n, .parallel_serial_pin,
  .bus_style_select, .chip_select_n, .data_command_select, .read_strobe_pin,
  .write_strobe_pin, .data_out, .data_oe_n, .mode, .addr, .status_flags);
